// File: logic/tag_guard_map.vh
// Purpose: block addresses, settings fields and defaults for the tag memory guard
// Assumes: 8-bit block addresses, 32-bit blocks
// Notes:   definitions only
`ifndef TAG_GUARD_MAP_VH
`define TAG_GUARD_MAP_VH
`define BLK_SECRET        8'hFE
`define BLK_SETTINGS      8'hFF
`define BLK_ID_FIRST      8'h00
`define BLK_ID_LAST       8'h03
`define BLK_USER_FIRST    8'h04
`define BLK_USER_LAST     8'h0F
`define BLK_SMALL_LAST    8'h03
`define BLK_LARGE_LAST    8'h0F
`define BIT_RATE_LO       0
`define BIT_RATE_HI       1
`define BIT_CODING        2
`define BIT_GUARD_ID      3
`define BIT_GUARD_USER    4
`define BIT_GUARD_UPPER_W 5
`define BIT_GUARD_UPPER_RW 6
`define SETTINGS_USED     8'h7F
`define SETTINGS_DEFAULT  8'h05
`define RATE_2K           2'h0
`define RATE_4K           2'h1
`define RATE_8K           2'h2
`define RATE_2K_CODE      2'h0
`define RATE_4K_CODE      2'h1
`define RATE_8K_CODE      2'h2
`define SECRET_DEFAULT    32'h0000_0000
`define RES_OK            2'h0
`define RES_DENIED        2'h1
`define RES_LOCKED        2'h2
`define RES_BAD_ADDR      2'h3
`endif

// File: logic/region_guard.v
// Purpose: decide whether one access to one block is allowed
// Assumes: settings byte and secret match are stable in the request cycle
// Notes:   purely combinational
`timescale 1ns/10ps
`include "tag_guard_map.vh"
module region_guard #(
  parameter LARGE = 1
) (
  input  wire [7:0] addr_i,
  input  wire       is_write_i,
  input  wire [7:0] settings_i,
  input  wire       secret_ok_i,
  input  wire       settings_locked_i,
  input  wire       secret_locked_i,
  output reg  [1:0] result_o
);
  wire in_id    = (addr_i <= `BLK_ID_LAST);
  wire in_user  = (LARGE != 0) && (addr_i >= `BLK_USER_FIRST) && (addr_i <= `BLK_USER_LAST);
  wire in_upper = (LARGE != 0) && (addr_i > `BLK_LARGE_LAST) && (addr_i < `BLK_SECRET);
  always @* begin
    result_o = `RES_OK;
    if (addr_i == `BLK_SETTINGS) begin
      if (is_write_i && settings_locked_i) // R9 R10
        result_o = `RES_LOCKED;
    end else if (addr_i == `BLK_SECRET) begin
      if (is_write_i && secret_locked_i) // R9
        result_o = `RES_LOCKED;
      else if (!is_write_i && !secret_ok_i) // secret never leaks unauthenticated
        result_o = `RES_DENIED;
    end else if (in_id) begin
      if (is_write_i && settings_i[`BIT_GUARD_ID] && !secret_ok_i) // R2 R12
        result_o = `RES_DENIED;
    end else if (in_user) begin
      if (is_write_i && settings_i[`BIT_GUARD_USER] && !secret_ok_i) // R3 R12
        result_o = `RES_DENIED;
    end else if (in_upper) begin
      if (!secret_ok_i && (settings_i[`BIT_GUARD_UPPER_RW] ||
          (is_write_i && settings_i[`BIT_GUARD_UPPER_W]))) // R4 R12
        result_o = `RES_DENIED;
    end else begin
      result_o = `RES_BAD_ADDR;
    end
  end
endmodule

// File: logic/tag_memory_access_guard.v
// Purpose: block store, settings byte, secret and lock control of the tag
// Assumes: air decoder presents one command per cycle on req_i, one block at a time
// Notes:   non-volatile store modelled as registers; secret match kept until the next auth command or reset
`timescale 1ns/10ps
`include "tag_guard_map.vh"
// Operation
// R1: store built of 32-bit blocks, whole-block access
// R2: id blocks write-guarded by settings bit3
// R3: user blocks write-guarded by settings bit4
// R4: upper area guarded, bit5 writes, bit6 all
// R5: tag-first coding and rate from low bits
// R6: reader-first replies Manchester at 4 kbit/s
// R7: shipped settings: bi-phase, 4 kbit/s
// R8: settings changed only by block-FF write
// R9: lock forbids later settings or secret writes
// R10: defaults stay writable until explicitly locked
// R11: only the low settings byte matters
// R12: guarded access needs matching 32-bit secret
module tag_memory_access_guard #(
  parameter LARGE  = 1,
  parameter BLOCKS = 16
) (
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire        ce_i,
  input  wire        req_i,
  input  wire [1:0]  cmd_i,
  input  wire [7:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        reader_speaks_first_mode_i,
  output reg         done_o,
  output reg  [1:0]  result_o,
  output reg  [31:0] rdata_o,
  output reg         biphase_coding_o,
  output reg  [1:0]  rate_o,
  output reg         secret_ok_o,
  output reg         settings_locked_o,
  output reg         secret_locked_o
);
  localparam CMD_READ  = 2'h0;
  localparam CMD_WRITE = 2'h1;
  localparam CMD_LOCK  = 2'h2;
  localparam CMD_AUTH  = 2'h3;

  reg  [31:0] store [0:BLOCKS-1]; // R1
  reg  [7:0]  settings_low_byte;
  reg  [31:0] access_secret;
  reg         secret_ok;
  reg         settings_locked;
  reg         secret_locked;
  wire [1:0]  verdict;
  wire        is_write = (cmd_i == CMD_WRITE);
  integer     i;

  region_guard #(.LARGE(LARGE)) u_guard (
    .addr_i            (addr_i),
    .is_write_i        (is_write),
    .settings_i        (settings_low_byte),
    .secret_ok_i       (secret_ok),
    .settings_locked_i (settings_locked),
    .secret_locked_i   (secret_locked),
    .result_o          (verdict)
  );

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (i = 0; i < BLOCKS; i = i + 1)
        store[i] <= 32'h0000_0000;
      settings_low_byte <= `SETTINGS_DEFAULT; // R7 R10
      access_secret     <= `SECRET_DEFAULT;
      secret_ok         <= 1'b0;
      settings_locked   <= 1'b0;
      secret_locked     <= 1'b0;
      done_o            <= 1'b0;
      result_o          <= `RES_OK;
      rdata_o           <= 32'h0000_0000;
    end else if (ce_i) begin
      done_o <= req_i;
      if (req_i) begin
        case (cmd_i)
          CMD_AUTH: begin
            secret_ok <= (wdata_i == access_secret); // R12
            result_o  <= (wdata_i == access_secret) ? `RES_OK : `RES_DENIED;
          end
          CMD_LOCK: begin
            if (addr_i == `BLK_SETTINGS) begin
              settings_locked <= 1'b1; // R9
              result_o        <= `RES_OK;
            end else if (addr_i == `BLK_SECRET) begin
              secret_locked <= 1'b1; // R9
              result_o      <= `RES_OK;
            end else begin
              result_o <= `RES_BAD_ADDR;
            end
          end
          CMD_READ: begin
            result_o <= verdict;
            if (verdict == `RES_OK) begin
              if (addr_i == `BLK_SETTINGS)
                rdata_o <= {24'h00_0000, settings_low_byte}; // R11
              else if (addr_i == `BLK_SECRET)
                rdata_o <= access_secret;
              else
                rdata_o <= store[addr_i[3:0]]; // R1
            end else begin
              rdata_o <= 32'h0000_0000;
            end
          end
          default: begin
            result_o <= verdict;
            if (verdict == `RES_OK) begin
              if (addr_i == `BLK_SETTINGS)
                settings_low_byte <= wdata_i[7:0] & `SETTINGS_USED; // R8 R11
              else if (addr_i == `BLK_SECRET)
                access_secret <= wdata_i;
              else
                store[addr_i[3:0]] <= wdata_i; // R1
            end
          end
        endcase
      end
    end
  end

  // return link setting: reader-first ignores the byte entirely
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      biphase_coding_o  <= 1'b0;
      rate_o            <= `RATE_4K_CODE;
      secret_ok_o       <= 1'b0;
      settings_locked_o <= 1'b0;
      secret_locked_o   <= 1'b0;
    end else if (ce_i) begin
      if (reader_speaks_first_mode_i) begin
        biphase_coding_o <= 1'b0; // R6
        rate_o           <= `RATE_4K_CODE; // R6
      end else begin
        biphase_coding_o <= settings_low_byte[`BIT_CODING]; // R5
        rate_o           <= settings_low_byte[`BIT_RATE_HI:`BIT_RATE_LO]; // R5
      end
      secret_ok_o       <= secret_ok;
      settings_locked_o <= settings_locked;
      secret_locked_o   <= secret_locked;
    end
  end
endmodule

// File: bench/tag_guard_checker.sv
// Purpose: port checks for the tag memory guard
// Assumes: ce_i held high
// Notes:   bound from the bench top file
`timescale 1ns/10ps
module tag_guard_checker (
  input wire        clk_i,
  input wire        rst_n_i,
  input wire        ce_i,
  input wire        req_i,
  input wire [1:0]  cmd_i,
  input wire [7:0]  addr_i,
  input wire        reader_speaks_first_mode_i,
  input wire        done_o,
  input wire [1:0]  result_o,
  input wire [31:0] rdata_o,
  input wire        biphase_coding_o,
  input wire [1:0]  rate_o,
  input wire        secret_ok_o,
  input wire        settings_locked_o,
  input wire        secret_locked_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_done_follow: assert property (req_i && ce_i |=> done_o) else $error("no done");
  chk_done_cause: assert property (done_o |-> $past(req_i)) else $error("stray done");
  chk_answer_hold: assert property (!done_o |-> $stable(result_o) && $stable(rdata_o)) else $error("moved");
  chk_refused_zero: assert property (done_o && result_o == 2'h1 && $past(cmd_i) == 2'h0
    |-> rdata_o == 32'h0000_0000) else $error("refused read leaks");
  chk_secret_read: assert property (done_o && result_o == 2'h0 && $past(cmd_i) == 2'h0
    && $past(addr_i) == 8'hFE |-> secret_ok_o) else $error("secret read unguarded");
  chk_rtf_fixed: assert property (reader_speaks_first_mode_i [*2]
    |-> !biphase_coding_o && rate_o == 2'h1) else $error("reply format");
  chk_lock_keep: assert property (settings_locked_o |=> settings_locked_o) else $error("unlock");
  chk_secret_keep: assert property (secret_locked_o |=> secret_locked_o) else $error("unlock");
  chk_locked_write: assert property (req_i && cmd_i == 2'h1 && addr_i == 8'hFF && settings_locked_o
    |=> result_o == 2'h2) else $error("locked write taken");
endmodule

// File: bench/reader_model.sv
// Purpose: remote reader issuing block commands
// Assumes: answer one cycle after the strobe
// Notes:   released address and data lines carry the inverse of the last value; cmd_o keeps it
`timescale 1ns/10ps
module reader_model (
  input  wire        clk_i,
  input  wire        done_i,
  input  wire [1:0]  result_i,
  input  wire [31:0] rdata_i,
  output reg         req_o = 1'h0,
  output reg  [1:0]  cmd_o = 2'h0,
  output reg  [7:0]  addr_o = 8'h00,
  output reg  [31:0] wdata_o = 32'h0000_0000
);
  task xfer(input [1:0] c, input [7:0] a, input [31:0] d, output [1:0] r, output [31:0] q);
    begin
      @(posedge clk_i);
      req_o   <= 1'h1;
      cmd_o   <= c;
      addr_o  <= a;
      wdata_o <= d;
      @(posedge clk_i);
      req_o   <= 1'h0;
      addr_o  <= ~a;
      wdata_o <= ~d;
      #1;
      r = (done_i === 1'h1) ? result_i : 2'hx;
      q = rdata_i;
    end
  endtask
endmodule

// File: bench/test_tag_memory_access_guard.sv
// Purpose: self-checking bench for the tag memory guard
// Assumes: reader model issues every command
// Notes:   coding and mode cases by hand first, then table cases with locks, then a ce_i freeze case
`timescale 1ns/10ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin miscompares++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module test_tag_memory_access_guard;
  reg         clk_i = 1'h0, rst_n_i = 1'h0, ce_i = 1'h1, mode = 1'h0;
  wire        req_i, done_o, biphase_coding_o, settings_locked_o, secret_locked_o, secret_ok_o;
  wire [1:0]  cmd_i, result_o, rate_o;
  wire [7:0]  addr_i;
  wire [31:0] wdata_i, rdata_o;
  reg  [1:0]  r;
  reg  [31:0] q;
  reg  [43:0] rows [0:19];
  int         miscompares = 0, check_count = 0, cyc = 0, i;
  tag_memory_access_guard i_dut (.clk_i, .rst_n_i, .ce_i, .req_i, .cmd_i, .addr_i, .wdata_i,
    .reader_speaks_first_mode_i(mode), .done_o, .result_o, .rdata_o, .biphase_coding_o, .rate_o,
    .secret_ok_o, .settings_locked_o, .secret_locked_o);
  reader_model i_rdr (.clk_i, .done_i(done_o), .result_i(result_o), .rdata_i(rdata_o),
    .req_o(req_i), .cmd_o(cmd_i), .addr_o(addr_i), .wdata_o(wdata_i));
  task stop_test;
    begin
      if (miscompares == 0 && check_count > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  initial forever #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      miscompares++;
      stop_test;
    end
  end
  initial begin
    // cmd, block, data or expected read data, expected result
    rows = '{{2'h1, 8'h00, 32'hA5A5_0001, 2'h0}, {2'h0, 8'h00, 32'hA5A5_0001, 2'h0},
      {2'h1, 8'h04, 32'h5A5A_0004, 2'h0}, {2'h0, 8'h04, 32'h5A5A_0004, 2'h0},
      {2'h1, 8'hFF, 32'hFFFF_FF7D, 2'h0}, {2'h0, 8'hFF, 32'h0000_007D, 2'h0},
      {2'h1, 8'h00, 32'h1111_1111, 2'h1}, {2'h0, 8'h00, 32'hA5A5_0001, 2'h0},
      {2'h1, 8'h0F, 32'h2222_2222, 2'h1}, {2'h0, 8'h04, 32'h5A5A_0004, 2'h0},
      {2'h0, 8'hFE, 32'h0000_0000, 2'h1}, {2'h0, 8'h10, 32'h0000_0000, 2'h1},
      {2'h3, 8'h00, 32'h0000_0000, 2'h0}, {2'h0, 8'hFE, 32'h0000_0000, 2'h0},
      {2'h1, 8'h00, 32'hC3C3_0000, 2'h0}, {2'h0, 8'h00, 32'hC3C3_0000, 2'h0},
      {2'h2, 8'hFE, 32'h0000_0000, 2'h0}, {2'h1, 8'hFE, 32'h1234_5678, 2'h2},
      {2'h2, 8'hFF, 32'h0000_0000, 2'h0}, {2'h1, 8'hFF, 32'h0000_0000, 2'h2}};
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    #1;
    `CHK("shipped", 3'h5, {biphase_coding_o, rate_o})
    for (i = 0; i < 3; i++) begin
      i_rdr.xfer(2'h1, 8'hFF, i | (i[0] << 2), r, q);
      @(posedge clk_i);
      #1;
      `CHK("coding", {i[0], i[1:0]}, {biphase_coding_o, rate_o})
    end
    @(posedge clk_i);
    mode <= 1'h1;
    repeat (2) @(posedge clk_i);
    #1;
    `CHK("reply", 3'h1, {biphase_coding_o, rate_o})
    @(posedge clk_i);
    mode <= 1'h0;
    for (i = 0; i < 20; i++) begin
      i_rdr.xfer(rows[i][43:42], rows[i][41:34], rows[i][33:2], r, q);
      `CHK("result", rows[i][1:0], r)
      if (rows[i][43:42] == 2'h0) `CHK("rdata", rows[i][33:2], q)
    end
    `CHK("locks", 2'h3, {settings_locked_o, secret_locked_o})
    `CHK("low byte", 3'h5, {biphase_coding_o, rate_o})
    `CHK("secret ok", 1'h1, secret_ok_o)
    @(posedge clk_i);
    ce_i <= 1'h0;
    i_rdr.xfer(2'h1, 8'h04, 32'h0000_0000, r, q);
    `CHK("frozen", 3'h2, {done_o, result_o})
    @(posedge clk_i);
    ce_i <= 1'h1;
    stop_test;
  end
endmodule
bind tag_memory_access_guard tag_guard_checker i_chk (.clk_i, .rst_n_i, .ce_i, .req_i, .cmd_i, .addr_i,
  .reader_speaks_first_mode_i, .done_o, .result_o, .rdata_o, .biphase_coding_o, .rate_o,
  .secret_ok_o, .settings_locked_o, .secret_locked_o);
